// ---- hdl/ird_pkg.sv ----
/*
 * Package for the infrared remote-control frame decoder: timing constants,
 * frame layout, receiver states, register offsets and reset values.
 * Assumes a 50 MHz system clock and a 38 kHz internal sequencing tick.
 */
`default_nettype none
package ird_pkg;
    // Clock rates and documented times.
    localparam int CLK_HZ         = 50000000;
    localparam int OSC_HZ         = 38000;
    localparam int HOLD_MS        = 160;
    localparam int SHOT_MS        = 107;
    // Derived counts: clock cycles per oscillator tick, ticks per timeout.
    localparam int OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;
    localparam int HOLD_TICKS_DEF = HOLD_MS * OSC_HZ / 1000;
    localparam int SHOT_TICKS_DEF = SHOT_MS * OSC_HZ / 1000;
    // Bit period and the idle time after which a lone first frame is dropped.
    localparam int BIT_TICKS      = 16;
    localparam int PAIR_GAP_DEF   = 64;
    localparam int FRAME_BITS     = 12;
    localparam int CNT_W          = 16;
    // Output group sizes.
    localparam int NUM_HOLD       = 6;
    localparam int NUM_SHOT       = 10;
    localparam int NUM_TOGGLE     = 2;
    // Variant encodings held in the control register.
    localparam logic [1:0] VAR_SMALL       = 2'h0;
    localparam logic [1:0] VAR_SMALL_TOG   = 2'h1;
    localparam logic [1:0] VAR_SMALL_CLEAR = 2'h2;
    localparam logic [1:0] VAR_LARGE       = 2'h3;
    // Register byte offsets.
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_OUTS   = 12'h008;
    localparam logic [11:0] OFF_COUNT  = 12'h00c;
    // Control register fields and reset values.
    localparam int CTRL_EN_BIT        = 0;
    localparam int CTRL_VAR_LSB       = 1;
    localparam logic       CTRL_EN_RST  = 1'b1;
    localparam logic [1:0] CTRL_VAR_RST = VAR_LARGE;

    // Frame layout, first bit received is the most significant.
    typedef struct packed {
        logic [2:0] code_bits;
        logic       hold_group;
        logic       first_shot_group;
        logic       second_shot_group;
        logic [5:0] key_select_lines;
    } ird_frame_type;

    // Decoded output set carried as one bundle.
    typedef struct packed {
        logic [NUM_TOGGLE-1:0] toggle_outputs;
        logic [NUM_SHOT-1:0]   oneshot_outputs;
        logic [NUM_HOLD-1:0]   hold_outputs;
    } ird_outs_type;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } ird_rx_state_type;
endpackage
`default_nettype wire

// ---- hdl/ird_decoder.sv ----
/*
 * Infrared remote-control frame decoder with an APB register slave.
 * Assumes RX_IN carries the demodulated frame (high while light is seen) and
 * CODE_PIN the two selectable code bits; both are asynchronous to REF_CLK.
 */
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
// Function
// - First frame of pair stored in shift register.
// - Repeat frame shifts out stored bit, compares.
// - First mismatch resets reception, outputs untouched.
// - Only full match makes command valid.
// - Bits sampled at bit period centre.
// - Latch strobe only when code bits agree.
// - Code mismatch: no strobe, outputs unchanged.
// - Small variant: first code bit fixed one.
// - Large variant: third code bit fixed one.
// - One-shot output high about 107 ms.
// - Hold output rises on strobe, stays meanwhile.
// - Hold output falls 160 ms after strobe.
// - Up to six hold outputs together.
// - Cyclic command inverts its toggle output.
// - Frame: code, group flags, six key lines.
// - Variant decides which keys are decoded.
// - Clearing variant: hold one/two clears toggle one.
// - All timing from a 38 kHz tick.
module ird_decoder #(
    parameter int OSC_DIV    = ird_pkg::OSC_DIV_CYCLES,
    parameter int HOLD_TICKS = ird_pkg::HOLD_TICKS_DEF,
    parameter int SHOT_TICKS = ird_pkg::SHOT_TICKS_DEF,
    parameter int PAIR_GAP   = ird_pkg::PAIR_GAP_DEF
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        RX_IN,
    input  wire logic [1:0]  CODE_PIN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic [5:0]       HOLD_OUT,
    output logic [9:0]       ONESHOT_OUT,
    output logic [1:0]       TOGGLE_OUT,
    output logic             LATCH_STROBE
);
    localparam int CW = ird_pkg::CNT_W;

    logic                       rx_meta_reg;
    logic                       rx_sync_reg;
    logic [1:0]                 code_meta_reg;
    logic [1:0]                 code_sync_reg;
    logic [CW-1:0]              div_cnt_reg;
    logic                       tick;
    ird_pkg::ird_rx_state_type  state_reg;
    logic [4:0]                 phase_reg;
    logic [3:0]                 bit_idx_reg;
    logic [11:0]                shift_reg;
    logic                       have_first_reg;
    logic [CW-1:0]              gap_cnt_reg;
    logic                       sample_en;
    logic                       last_bit;
    logic                       mismatch;
    logic                       check_ok;
    logic                       code_ok;
    logic [2:0]                 code_local;
    ird_pkg::ird_frame_type     cand;
    logic                       ctrl_en_reg;
    logic [1:0]                 variant_reg;
    logic [5:0]                 hold_mask;
    logic [9:0]                 shot_mask;
    logic [1:0]                 tog_mask;
    logic [5:0]                 key_idx;
    logic [5:0]                 hold_set;
    logic [9:0]                 shot_set;
    logic [1:0]                 tog_set;
    ird_pkg::ird_outs_type      outs;
    logic [5:0]                 hold_reg;
    logic [CW-1:0]              hold_cnt_reg;
    logic [9:0]                 shot_reg;
    logic [CW-1:0]              shot_cnt_reg [10];
    logic [1:0]                 tog_reg;
    logic                       tog_clear;
    logic [CW-1:0]              good_cnt_reg;
    logic [CW-1:0]              bad_cnt_reg;
    logic                       apb_setup;
    logic                       apb_write;
    logic                       hit_ctrl;
    logic                       hit_status;
    logic                       hit_outs;
    logic                       hit_count;
    logic                       hit_any;
    logic [31:0]                rd_mux;

    // Receive line and code pins pass two flip-flops before use.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rx_meta_reg   <= 1'b0;
            rx_sync_reg   <= 1'b0;
            code_meta_reg <= 2'h0;
            code_sync_reg <= 2'h0;
        end else begin
            rx_meta_reg   <= RX_IN;
            rx_sync_reg   <= rx_meta_reg;
            code_meta_reg <= CODE_PIN;
            code_sync_reg <= code_meta_reg;
        end
    end

    // Divider making the one-cycle sequencing tick.
    assign tick = (div_cnt_reg == CW'(OSC_DIV - 1));
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= tick ? '0 : div_cnt_reg + 16'h0001;
        end
    end

    // Sampling strobe fires a bit and a half after the start edge, then once a bit.
    assign sample_en  = tick && (state_reg == ird_pkg::RX_DATA) &&
                        (phase_reg == 5'(ird_pkg::BIT_TICKS - 1));
    assign last_bit   = sample_en && (bit_idx_reg == 4'(ird_pkg::FRAME_BITS - 1));
    assign mismatch   = sample_en && have_first_reg && (shift_reg[11] != rx_sync_reg);
    assign check_ok   = last_bit && have_first_reg && !mismatch;
    assign cand       = ird_pkg::ird_frame_type'({shift_reg[10:0], rx_sync_reg});

    // Local code with the pulled-up bit depending on the variant.
    assign code_local = (variant_reg == ird_pkg::VAR_LARGE) ?
                        {code_sync_reg[1], code_sync_reg[0], 1'b1} :
                        {1'b1, code_sync_reg[1], code_sync_reg[0]};
    assign code_ok      = (cand.code_bits == code_local);
    assign LATCH_STROBE = check_ok && code_ok && ctrl_en_reg;

    // Frame receiver: start bit, twelve data bits, then wait for line idle.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_reg      <= ird_pkg::RX_IDLE;
            phase_reg      <= '0;
            bit_idx_reg    <= '0;
            shift_reg      <= '0;
            have_first_reg <= 1'b0;
            gap_cnt_reg    <= '0;
        end else if (tick) begin
            phase_reg <= phase_reg + 5'h01;
            case (state_reg)
                ird_pkg::RX_IDLE: begin
                    phase_reg <= '0;
                    if (rx_sync_reg) begin
                        state_reg   <= ird_pkg::RX_START;
                        gap_cnt_reg <= '0;
                    end else if (have_first_reg) begin
                        gap_cnt_reg <= gap_cnt_reg + 16'h0001;
                        if (gap_cnt_reg == CW'(PAIR_GAP - 1)) begin
                            have_first_reg <= 1'b0;
                            shift_reg      <= '0;
                        end
                    end
                end
                ird_pkg::RX_START: begin
                    if (phase_reg == 5'(ird_pkg::BIT_TICKS / 2 - 1)) begin
                        phase_reg   <= '0;
                        bit_idx_reg <= '0;
                        state_reg   <= rx_sync_reg ? ird_pkg::RX_DATA : ird_pkg::RX_IDLE;
                    end
                end
                ird_pkg::RX_DATA: begin
                    if (sample_en) begin
                        phase_reg   <= '0;
                        bit_idx_reg <= bit_idx_reg + 4'h1;
                        shift_reg   <= {shift_reg[10:0], rx_sync_reg};
                        if (mismatch) begin
                            have_first_reg <= 1'b0;
                            shift_reg      <= '0;
                            state_reg      <= ird_pkg::RX_STOP;
                        end else if (last_bit) begin
                            have_first_reg <= !have_first_reg;
                            state_reg      <= ird_pkg::RX_STOP;
                        end
                    end
                end
                default: begin
                    phase_reg <= '0;
                    if (!rx_sync_reg) begin
                        state_reg <= ird_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Which outputs each variant decodes.
    assign hold_mask = (variant_reg == ird_pkg::VAR_LARGE) ? 6'h3f : 6'h1f;
    assign shot_mask = (variant_reg == ird_pkg::VAR_LARGE) ? 10'h3ff :
                       (variant_reg == ird_pkg::VAR_SMALL) ? 10'h01f : 10'h007;
    assign tog_mask  = (variant_reg == ird_pkg::VAR_SMALL) ? 2'h0 : 2'h3;

    // Group flag picks the output bank, key lines pick the index.
    // The first key line arrives first, so it sits at the top of the field; key_idx[0] is the first key.
    assign key_idx  = {cand.key_select_lines[0], cand.key_select_lines[1], cand.key_select_lines[2],
                       cand.key_select_lines[3], cand.key_select_lines[4], cand.key_select_lines[5]};
    assign hold_set = (LATCH_STROBE && cand.hold_group) ?
                      (key_idx & hold_mask) : 6'h00;
    assign shot_set = LATCH_STROBE ? ({(cand.second_shot_group ? key_idx[3:0] : 4'h0),
                                       (cand.first_shot_group ? key_idx : 6'h00)}
                                      & shot_mask) : 10'h000;
    assign tog_set  = (LATCH_STROBE && cand.second_shot_group) ?
                      (key_idx[5:4] & tog_mask) : 2'h0;
    assign tog_clear = (variant_reg == ird_pkg::VAR_SMALL_CLEAR) && (hold_reg[0] || hold_reg[1]);

    // Hold bank: set by strobes, dropped together after the hold time.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            hold_reg     <= '0;
            hold_cnt_reg <= '0;
        end else if (hold_set != 6'h00) begin
            hold_reg     <= hold_reg | hold_set;
            hold_cnt_reg <= CW'(HOLD_TICKS);
        end else if (tick && (hold_cnt_reg != '0)) begin
            hold_cnt_reg <= hold_cnt_reg - 16'h0001;
            if (hold_cnt_reg == 16'h0001) begin
                hold_reg <= '0;
            end
        end
    end

    // One-shot bank: a running pulse is not stretched by later frames.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            shot_reg <= '0;
            for (int i = 0; i < 10; i++) begin
                shot_cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 10; i++) begin
                if (shot_set[i] && !shot_reg[i]) begin
                    shot_reg[i]     <= 1'b1;
                    shot_cnt_reg[i] <= CW'(SHOT_TICKS);
                end else if (tick && (shot_cnt_reg[i] != '0)) begin
                    shot_cnt_reg[i] <= shot_cnt_reg[i] - 16'h0001;
                    if (shot_cnt_reg[i] == 16'h0001) begin
                        shot_reg[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // Toggle bank, with the forced clear of the first toggle taking priority.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tog_reg <= '0;
        end else begin
            tog_reg <= (tog_reg ^ tog_set) & {1'b1, !tog_clear};
        end
    end

    assign outs.hold_outputs    = hold_reg;
    assign outs.oneshot_outputs = shot_reg;
    assign outs.toggle_outputs  = tog_reg;
    assign HOLD_OUT    = outs.hold_outputs;
    assign ONESHOT_OUT = outs.oneshot_outputs;
    assign TOGGLE_OUT  = outs.toggle_outputs;

    // Counters of accepted strobes and of rejected repeat frames.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            good_cnt_reg <= '0;
            bad_cnt_reg  <= '0;
        end else begin
            if (LATCH_STROBE) begin
                good_cnt_reg <= good_cnt_reg + 16'h0001;
            end
            if (mismatch || (check_ok && !code_ok)) begin
                bad_cnt_reg <= bad_cnt_reg + 16'h0001;
            end
        end
    end

    // APB decode; every access completes with no wait state.
    assign apb_setup  = PSEL && !PENABLE;
    assign apb_write  = PSEL && PENABLE && PWRITE;
    assign hit_ctrl   = (PADDR == ird_pkg::OFF_CTRL);
    assign hit_status = (PADDR == ird_pkg::OFF_STATUS);
    assign hit_outs   = (PADDR == ird_pkg::OFF_OUTS);
    assign hit_count  = (PADDR == ird_pkg::OFF_COUNT);
    assign hit_any    = hit_ctrl || hit_status || hit_outs || hit_count;
    assign PREADY     = 1'b1;
    assign PSLVERR    = PSEL && PENABLE && !hit_any;
    assign rd_mux = hit_ctrl   ? {29'h0, variant_reg, ctrl_en_reg} :
                    hit_status ? {25'h0, code_local, 2'h0,
                                  (state_reg != ird_pkg::RX_IDLE), have_first_reg} :
                    hit_outs   ? {14'h0, outs} :
                    hit_count  ? {bad_cnt_reg, good_cnt_reg} : 32'h0000_0000;

    // Control register write in the access cycle, read data capture in the setup cycle.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ctrl_en_reg <= ird_pkg::CTRL_EN_RST;
            variant_reg <= ird_pkg::CTRL_VAR_RST;
            PRDATA      <= '0;
        end else begin
            if (apb_write && hit_ctrl) begin
                ctrl_en_reg <= PWDATA[ird_pkg::CTRL_EN_BIT];
                variant_reg <= PWDATA[ird_pkg::CTRL_VAR_LSB +: 2];
            end
            if (apb_setup) begin
                PRDATA <= rd_mux;
            end
        end
    end

    // Checks on the decoder's own behaviour.
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_pair_ok;
        check_ok && code_ok && ctrl_en_reg;
    endsequence

    a_mismatch_resets: assert property (mismatch |=> !have_first_reg && (state_reg == ird_pkg::RX_STOP))
        else $error("Mismatch did not reset reception.");
    a_check_after_first: assert property (check_ok |-> have_first_reg ##1 !have_first_reg)
        else $error("Repeat check without stored first frame.");
    a_strobe_cause: assert property (LATCH_STROBE |-> s_pair_ok)
        else $error("Latch strobe without matching code.");
    a_code_reject: assert property (check_ok && !code_ok |-> !LATCH_STROBE ##1 $stable(outs))
        else $error("Code mismatch changed outputs.");
    a_sample_centre: assert property (sample_en |-> state_reg == ird_pkg::RX_DATA &&
                                      phase_reg == 5'(ird_pkg::BIT_TICKS - 1))
        else $error("Bit sampled off centre.");
    a_pinned_code: assert property ((variant_reg == ird_pkg::VAR_LARGE) ? code_local[0] : code_local[2])
        else $error("Pulled-up code bit not one.");
    a_shot_start: assert property ($rose(shot_reg[0]) |-> $past(LATCH_STROBE) && shot_cnt_reg[0] == CW'(SHOT_TICKS))
        else $error("One-shot rose without strobe or load.");
    a_hold_reload: assert property (hold_set != 6'h00 |=> hold_cnt_reg == CW'(HOLD_TICKS) && (hold_reg != 6'h00))
        else $error("Hold output not loaded.");
    a_toggle_flip: assert property (tog_set[1] |=> tog_reg[1] != $past(tog_reg[1]))
        else $error("Toggle did not invert.");
    a_toggle_clear: assert property (tog_clear |=> !tog_reg[0])
        else $error("First toggle not cleared by hold.");
endmodule
`default_nettype wire

// ---- dv/ird_tx_model.sv ----
/*
 * Behavioural remote transmitter seen through the light detector.
 * Assumes the receiver samples RX_IN on REF_CLK and that the bench calls send_pair.
 */
`timescale 1ns/100ps
`default_nettype none
module ird_tx_model #(
    parameter int BIT_CYC = 64,
    parameter int GAP_CYC = 128
) (
    input  wire logic REF_CLK,
    output var  logic RX_IN
);
    // The line is dark while no frame is sent.
    initial begin
        RX_IN = 1'b0;
    end

    // Sends a start mark, then twelve bits with the first code bit first.
    task automatic send_frame(input logic [11:0] f);
        @(posedge REF_CLK);
        RX_IN <= 1'b1;
        repeat (BIT_CYC) @(posedge REF_CLK);
        for (int i = 11; i >= 0; i--) begin
            RX_IN <= f[i];
            repeat (BIT_CYC) @(posedge REF_CLK);
        end
        RX_IN <= 1'b0;
        repeat (GAP_CYC) @(posedge REF_CLK);
    endtask

    // Every command goes out twice; the second copy may differ on purpose.
    task automatic send_pair(input logic [11:0] f1, input logic [11:0] f2);
        send_frame(f1);
        send_frame(f2);
    endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
/*
 * Self-checking bench for the frame decoder: a table of frame pairs, then hand tests.
 * Assumes ird_tx_model drives RX_IN and the registers are reached over APB.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [11:0] f1;
        logic [11:0] f2;
        logic        acc;
        logic [17:0] exp;
    } ird_row_type;
    localparam int DIV  = 4;
    localparam int HOLD = 600;
    localparam int SHOT = 12;
    logic                  ref_clk;
    logic                  rst;
    logic                  rx_in;
    logic [1:0]            code_pin;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [5:0]            hold_out;
    logic [9:0]            shot_out;
    logic [1:0]            tog_out;
    logic                  strobe;
    ird_pkg::ird_outs_type outs;
    int                    n_fail;
    int                    checks_done;
    logic                  got;
    logic [31:0]           rd;
    logic                  err;
    ird_row_type           rows [10] = '{
        '{12'hb20, 12'hb20, 1'b1, 18'h00001}, '{12'hb3f, 12'hb3f, 1'b1, 18'h0003f},
        '{12'haa0, 12'haa0, 1'b1, 18'h00040}, '{12'ha81, 12'ha81, 1'b1, 18'h00800},
        '{12'ha44, 12'ha44, 1'b1, 18'h08000}, '{12'ha42, 12'ha42, 1'b1, 18'h10000},
        '{12'ha41, 12'ha41, 1'b1, 18'h30000}, '{12'ha42, 12'ha42, 1'b1, 18'h20000},
        '{12'h720, 12'h720, 1'b0, 18'h20000}, '{12'hb20, 12'hb28, 1'b0, 18'h20000}};

    // Output bundle gathered for whole-set comparisons.
    assign outs = {tog_out, shot_out, hold_out};

    ird_decoder #(.OSC_DIV(DIV), .HOLD_TICKS(HOLD), .SHOT_TICKS(SHOT), .PAIR_GAP(64)) u_ird_decoder (
        .REF_CLK(ref_clk), .RST(rst), .RX_IN(rx_in), .CODE_PIN(code_pin), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .HOLD_OUT(hold_out), .ONESHOT_OUT(shot_out),
        .TOGGLE_OUT(tog_out), .LATCH_STROBE(strobe));

    ird_tx_model u_ird_tx_model (.REF_CLK(ref_clk), .RX_IN(rx_in));

    // Free-running 50 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp_o(input ird_pkg::ird_outs_type g, input ird_pkg::ird_outs_type e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t outs got %h exp %h", $time, g, e);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_strobe(input int lim);
        got = 1'b0;
        for (int i = 0; i < lim && got !== 1'b1; i++) begin
            @(negedge ref_clk);
            if (strobe === 1'b1) got = 1'b1;
        end
    endtask

    // Sends one pair and checks the strobe and the outputs just after it.
    task automatic run_pair(input logic [11:0] f1, input logic [11:0] f2, input logic acc,
                            input logic [17:0] e);
        fork
            u_ird_tx_model.send_pair(f1, f2);
        join_none
        wait_strobe(2500);
        cmp_w({31'h0, got}, {31'h0, acc});
        repeat (2) @(negedge ref_clk);
        cmp_o(outs, e);
        wait fork;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Cuts a hang short well after the expected run length.
    initial begin
        #1900000;
        n_fail++;
        close_out();
    end

    // Main sequence: reset, table of pairs, then timing and variant cases.
    initial begin
        n_fail = 0;
        checks_done = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        code_pin = 2'b10;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        cmp_o(outs, 18'h0);
        apb(1'b0, ird_pkg::OFF_CTRL, 32'h0);
        cmp_w(rd, 32'h7);
        apb(1'b1, ird_pkg::OFF_STATUS, 32'hffffffff);
        apb(1'b0, ird_pkg::OFF_STATUS, 32'h0);
        cmp_w(rd, 32'h50);
        apb(1'b0, 12'h010, 32'h0);
        cmp_w({31'h0, err}, 32'h1);
        cmp_w(rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            run_pair(rows[i].f1, rows[i].f2, rows[i].acc, rows[i].exp);
            repeat (HOLD * DIV + 100) @(negedge ref_clk);
        end
        apb(1'b0, ird_pkg::OFF_COUNT, 32'h0);
        cmp_w(rd, 32'h00020008);
        $display("test table done");
        fork
            u_ird_tx_model.send_pair(12'haa0, 12'haa0);
        join_none
        wait_strobe(2500);
        repeat (SHOT * DIV - 8) @(negedge ref_clk);
        cmp_o(outs, 18'h20040);
        repeat (16) @(negedge ref_clk);
        cmp_o(outs, 18'h20000);
        wait fork;
        $display("test oneshot done");
        fork
            begin
                u_ird_tx_model.send_pair(12'hb10, 12'hb10);
                u_ird_tx_model.send_pair(12'hb10, 12'hb10);
            end
        join_none
        wait_strobe(2500);
        wait_strobe(2500);
        repeat (2) @(negedge ref_clk);
        cmp_o(outs, 18'h20002);
        repeat (HOLD * DIV - 10) @(negedge ref_clk);
        cmp_o(outs, 18'h20002);
        repeat (20) @(negedge ref_clk);
        cmp_o(outs, 18'h20000);
        wait fork;
        $display("test hold done");
        apb(1'b1, ird_pkg::OFF_CTRL, 32'h5);
        apb(1'b0, ird_pkg::OFF_STATUS, 32'h0);
        cmp_w(rd, 32'h60);
        run_pair(12'hc42, 12'hc42, 1'b1, 18'h30000);
        run_pair(12'hd20, 12'hd20, 1'b1, 18'h20001);
        $display("test clearing variant done");
        // Strobes disabled, then keys that the two small variants do not decode.
        repeat (HOLD * DIV + 100) @(negedge ref_clk);
        apb(1'b1, ird_pkg::OFF_CTRL, 32'h0);
        run_pair(12'hc42, 12'hc42, 1'b0, 18'h20000);
        apb(1'b1, ird_pkg::OFF_CTRL, 32'h1);
        run_pair(12'hc81, 12'hc81, 1'b1, 18'h20000);
        apb(1'b1, ird_pkg::OFF_CTRL, 32'h3);
        run_pair(12'hc84, 12'hc84, 1'b1, 18'h20000);
        $display("test small variants done");
        close_out();
    end
endmodule
`default_nettype wire
